// ===== common/sbf_pkg.sv
// Purpose: Shared constants and carrier types for the slip buffer and signaling freeze control.
// Assumes: Register indices are word indices; the APB byte address is four times the index.
// Notes:   Channel offset (the N digit) is taken as zero.
package sbf_pkg;
  // Register word indices
  localparam logic [11:0] IDX_CTRL     = 12'h116;
  localparam logic [11:0] IDX_LAT      = 12'h117;
  localparam logic [11:0] IDX_IRQ_STAT = 12'h120;
  localparam logic [11:0] IDX_IRQ_MASK = 12'h121;
  localparam logic [11:0] IDX_SIG_BASE = 12'h500;
  localparam int          SIG_ENTRIES  = 32;
  // Control register fields
  localparam int          CTRL_TXFIFO  = 7;
  localparam int          CTRL_FORCE   = 4;
  localparam int          CTRL_SFEN    = 3;
  localparam int          CTRL_SDIR    = 2;
  localparam logic [7:0]  CTRL_RESET   = 8'h05;
  localparam logic [7:0]  CTRL_RW_MASK = 8'h9F;
  localparam logic [4:0]  LAT_RESET    = 5'h00;
  // Receive buffer mode codes; 00 and 11 bypass
  localparam logic [1:0]  MODE_SLIP    = 2'h1;
  localparam logic [1:0]  MODE_FIFO    = 2'h2;
  // Interrupt status bits
  localparam int          IRQ_RX_SLIP  = 0;
  localparam int          IRQ_TX_SLIP  = 1;
  localparam int          IRQ_BITS     = 2;
  localparam int          FRAME_BITS_E1 = 256;

  typedef struct packed {
    logic        psel;
    logic        penable;
    logic        pwrite;
    logic [15:0] paddr;
    logic [31:0] pwdata;
  } sbf_apb_req_t;

  typedef struct packed {
    logic       valid;
    logic [4:0] slot;
    logic [3:0] bits;
  } sbf_sig_update_t;
endpackage : sbf_pkg

// ===== src/sbf_sig_freeze.sv
// Purpose: Decides when receive signaling updates are held back.
// Assumes: mf_start pulses once per receive multiframe.
// Notes:   After a slip the hold runs to the end of the next full multiframe.
`timescale 1ns/1ps
module sbf_sig_freeze (
  // Clock and reset
  input  wire logic clock,
  input  wire logic rst,
  // Control and events
  input  wire logic force_signaling_freeze,
  input  wire logic slip_freeze_enable,
  input  wire logic slip,
  input  wire logic mf_start,
  // Result
  output logic      freeze
);
  import sbf_pkg::*;
  typedef enum logic [1:0] {FZ_IDLE, FZ_WAIT, FZ_HOLD} sbf_fz_t;
  sbf_fz_t state;
  sbf_fz_t next_state;
  logic    next_freeze;

  always_comb begin
    next_state = state;
    case (state)
      FZ_IDLE: next_state = FZ_IDLE;
      FZ_WAIT: if (mf_start) next_state = FZ_HOLD;
      FZ_HOLD: if (mf_start) next_state = FZ_IDLE;
      default: next_state = FZ_IDLE;
    endcase
    if (slip) begin
      next_state = FZ_WAIT;
    end
    if (!slip_freeze_enable) begin
      next_state = FZ_IDLE;
    end
    next_freeze = force_signaling_freeze || (next_state != FZ_IDLE);
  end

  always_ff @(posedge clock or posedge rst) begin
    if (rst) begin
      state  <= FZ_IDLE;
      freeze <= 1'b0;
    end else begin
      state  <= next_state;
      freeze <= next_freeze;
    end
  end

  force_hold_a: assert property (@(posedge clock) disable iff (rst)
    force_signaling_freeze |=> freeze) else $error("forced freeze not applied");
  slip_hold_a: assert property (@(posedge clock) disable iff (rst)
    slip && slip_freeze_enable ##1 !mf_start && slip_freeze_enable |=> freeze) else $error("freeze after slip missing");
  no_freeze_a: assert property (@(posedge clock) disable iff (rst)
    !force_signaling_freeze && !slip_freeze_enable |=> !freeze) else $error("freeze while disabled");
endmodule : sbf_sig_freeze

// ===== src/sbf_slip_buffer.sv
// Purpose: One-bit-wide two-frame buffer, run either as a slip buffer or as a fixed-latency FIFO.
// Assumes: Write and read strobes are single-cycle enables in the system clock domain.
// Notes:   A slip repeats or deletes one whole frame so frame alignment survives.
`timescale 1ns/1ps
module sbf_slip_buffer #(
  parameter int FRAME_BITS = 256
) (
  // Clock and reset
  input  wire logic       clock,
  input  wire logic       rst,
  // Mode
  input  wire logic       fifo_mode,
  input  wire logic [4:0] latency,
  // Write side
  input  wire logic       wr_valid,
  input  wire logic       wr_bit,
  // Read side
  input  wire logic       rd_strobe,
  output logic            rd_bit,
  output logic            slip
);
  import sbf_pkg::*;
  localparam int              DEPTH      = 2 * FRAME_BITS;
  localparam int              PW         = $clog2(DEPTH);
  localparam logic [PW-1:0]   FRAME_STEP = PW'(FRAME_BITS);

  logic          mem [DEPTH];
  logic [PW-1:0] wr_ptr;
  logic [PW-1:0] next_wr_ptr;
  logic [PW-1:0] rd_ptr;
  logic [PW-1:0] next_rd_ptr;
  logic [PW-1:0] rd_idx;
  logic          next_rd_bit;
  logic          next_slip;

  always_comb begin
    next_wr_ptr = wr_ptr;
    next_rd_ptr = rd_ptr;
    next_rd_bit = rd_bit;
    next_slip   = 1'b0;
    rd_idx      = rd_ptr;
    if (wr_valid) begin
      next_wr_ptr = wr_ptr + 1'b1;
    end
    if (fifo_mode) begin
      // Read trails write by exactly the programmed count of bits
      rd_idx      = wr_ptr - PW'(latency) - 1'b1;
      next_rd_ptr = wr_ptr;
      if (rd_strobe) begin
        next_rd_bit = mem[rd_idx];
      end
    end else begin
      if (rd_strobe) begin
        if (rd_ptr == wr_ptr) begin
          // Underrun: replay the previous frame
          rd_idx    = rd_ptr - FRAME_STEP;
          next_slip = 1'b1;
        end
        next_rd_bit = mem[rd_idx];
        next_rd_ptr = rd_idx + 1'b1;
      end
      if (wr_valid && next_wr_ptr == next_rd_ptr) begin
        // Overrun: skip one whole frame
        next_rd_ptr = next_rd_ptr + FRAME_STEP;
        next_slip   = 1'b1;
      end
    end
  end

  always_ff @(posedge clock) begin
    if (wr_valid) begin
      mem[wr_ptr] <= wr_bit;
    end
  end

  always_ff @(posedge clock or posedge rst) begin
    if (rst) begin
      wr_ptr <= '0;
      rd_ptr <= '0;
      rd_bit <= 1'b0;
      slip   <= 1'b0;
    end else begin
      wr_ptr <= next_wr_ptr;
      rd_ptr <= next_rd_ptr;
      rd_bit <= next_rd_bit;
      slip   <= next_slip;
    end
  end

  no_fifo_slip_a: assert property (@(posedge clock) disable iff (rst)
    fifo_mode |=> !slip) else $error("slip flagged in FIFO operation");
endmodule : sbf_slip_buffer

// ===== src/sbf_slip_ctl.sv
// Purpose: Slip buffer, FIFO and signaling freeze control for one E1 channel, with APB registers.
// Assumes: All pins are synchronous to clock; serial clocks are sampled and edge-detected.
// Notes:   Behaviour
`timescale 1ns/1ps
module sbf_slip_ctl #(
  parameter int FRAME_BITS = 256
) (
  // Clock and reset
  input  wire logic                    clock,
  input  wire logic                    rst,
  // APB slave
  input  wire sbf_pkg::sbf_apb_req_t   apb_req,
  output logic [31:0]                  prdata,
  output logic                         pready,
  output logic                         pslverr,
  // Receive line side
  input  wire logic                    line_clock,
  input  wire logic                    line_bit_valid,
  input  wire logic                    line_bit,
  input  wire logic                    line_frame_start,
  input  wire logic                    line_mf_start,
  // Receive serial port
  input  wire logic                    rx_serial_clock_in,
  output logic                         rx_serial_clock_out,
  output logic                         rx_serial_clock_oe,
  input  wire logic                    rx_frame_boundary_in,
  output logic                         rx_frame_boundary_out,
  output logic                         rx_frame_boundary_oe,
  output logic                         rx_ser_data,
  // Receive signaling
  input  wire sbf_pkg::sbf_sig_update_t sig_update,
  input  wire logic [4:0]              sig_slot_sel,
  output logic [3:0]                   rx_signaling_out,
  // Transmit serial port and line side
  input  wire logic                    high_speed_mode,
  input  wire logic                    tx_serial_clock_in,
  output logic                         tx_serial_clock_out,
  output logic                         tx_serial_clock_oe,
  input  wire logic                    tx_ser_data,
  input  wire logic                    tx_multiframe_sync,
  input  wire logic                    tx_line_strobe,
  output logic                         tx_line_bit,
  output logic                         tx_line_mf_start,
  // Interrupt
  output logic                         irq
);
  import sbf_pkg::*;
  localparam int CW = $clog2(FRAME_BITS);

  // Latency up to 31 must fit behind the write pointer
  if (FRAME_BITS < 32 || (FRAME_BITS & (FRAME_BITS - 1)) != 0) begin : g_bad_frame
    $error("FRAME_BITS must be a power of two and at least 32");
  end

  // Register state
  logic [7:0]          ctrl;
  logic [7:0]          next_ctrl;
  logic [4:0]          latency;
  logic [4:0]          next_latency;
  logic [IRQ_BITS-1:0] irq_stat;
  logic [IRQ_BITS-1:0] next_irq_stat;
  logic [IRQ_BITS-1:0] irq_mask;
  logic [IRQ_BITS-1:0] next_irq_mask;
  logic [31:0]         next_prdata;
  logic                next_pready;
  logic                next_pslverr;
  logic                next_irq;
  logic [11:0]         widx;
  logic                in_range;
  logic                access;
  logic                wr_en;
  // Decoded control
  logic [1:0]          rx_mode;
  logic                rx_buffered;
  logic                rx_fifo;
  logic                tx_fifo;
  logic                sdir_in;
  // Receive path
  logic                rxclk_d;
  logic                rx_rd_stb;
  logic                rx_rd_bit;
  logic                rx_slip;
  logic [CW-1:0]       rd_cnt;
  logic [CW-1:0]       next_rd_cnt;
  logic                next_rx_ser_data;
  logic                next_rxclk_out;
  logic                next_rxclk_oe;
  logic                next_fb_out;
  logic                next_fb_oe;
  // Signaling
  logic                freeze;
  logic [3:0]          sig_array [SIG_ENTRIES];
  logic [3:0]          next_sig_out;
  // Transmit path
  logic                txclk_d;
  logic                tx_wr_stb;
  logic                tx_rd_stb;
  logic                tx_rd_bit;
  logic                tx_slip;
  logic                next_tx_bit;
  logic                next_tx_mf;
  logic                next_txclk_out;
  logic                next_txclk_oe;

  assign rx_mode     = ctrl[1:0];
  assign rx_buffered = (rx_mode == MODE_SLIP) || (rx_mode == MODE_FIFO);
  assign rx_fifo     = (rx_mode == MODE_FIFO);
  assign tx_fifo     = ctrl[CTRL_TXFIFO];
  assign sdir_in     = ctrl[CTRL_SDIR];

  // APB decode; byte lanes are not used, every access is a full word
  assign widx     = apb_req.paddr[13:2];
  assign in_range = (apb_req.paddr[15:14] == 2'h0) && (apb_req.paddr[1:0] == 2'h0);
  assign access   = apb_req.psel && apb_req.penable;
  assign wr_en    = access && pready && apb_req.pwrite && !pslverr;

  always_comb begin
    next_ctrl     = ctrl;
    next_latency  = latency;
    next_irq_mask = irq_mask;
    next_irq_stat = irq_stat;
    if (wr_en && widx == IDX_IRQ_STAT) begin
      next_irq_stat = irq_stat & ~apb_req.pwdata[IRQ_BITS-1:0];
    end
    // A slip in the clearing cycle stays set
    next_irq_stat[IRQ_RX_SLIP] = next_irq_stat[IRQ_RX_SLIP] | rx_slip;
    next_irq_stat[IRQ_TX_SLIP] = next_irq_stat[IRQ_TX_SLIP] | tx_slip;
    if (wr_en) begin
      if (widx == IDX_CTRL) begin
        next_ctrl = apb_req.pwdata[7:0] & CTRL_RW_MASK;
      end else if (widx == IDX_LAT) begin
        next_latency = apb_req.pwdata[4:0];
      end else if (widx == IDX_IRQ_MASK) begin
        next_irq_mask = apb_req.pwdata[IRQ_BITS-1:0];
      end
    end
    // One wait state: pready rises in the second access cycle
    next_pready  = access && !pready;
    next_prdata  = 32'h0000_0000;
    next_pslverr = 1'b0;
    if (access && !pready) begin
      if (!in_range) begin
        next_pslverr = 1'b1;
      end else if (widx == IDX_CTRL) begin
        next_prdata[7:0] = ctrl;
      end else if (widx == IDX_LAT) begin
        next_prdata[4:0] = latency;
      end else if (widx == IDX_IRQ_STAT) begin
        next_prdata[IRQ_BITS-1:0] = irq_stat;
      end else if (widx == IDX_IRQ_MASK) begin
        next_prdata[IRQ_BITS-1:0] = irq_mask;
      end else if (widx[11:5] == IDX_SIG_BASE[11:5]) begin
        // Signaling array is read-only here; writes are ignored
        next_prdata[3:0] = sig_array[widx[4:0]];
      end else begin
        next_pslverr = 1'b1;
      end
    end
    next_irq = |(next_irq_stat & next_irq_mask);
  end

  always_ff @(posedge clock or posedge rst) begin
    if (rst) begin
      ctrl     <= CTRL_RESET;
      latency  <= LAT_RESET;
      irq_stat <= '0;
      irq_mask <= '0;
      prdata   <= 32'h0000_0000;
      pready   <= 1'b0;
      pslverr  <= 1'b0;
      irq      <= 1'b0;
    end else begin
      ctrl     <= next_ctrl;
      latency  <= next_latency;
      irq_stat <= next_irq_stat;
      irq_mask <= next_irq_mask;
      prdata   <= next_prdata;
      pready   <= next_pready;
      pslverr  <= next_pslverr;
      irq      <= next_irq;
    end
  end

  // Receive buffer: line writes, serial clock rising edges read
  assign rx_rd_stb = rx_serial_clock_in && !rxclk_d && rx_buffered;

  sbf_slip_buffer #(
    .FRAME_BITS (FRAME_BITS)
  ) u_rx_buf (
    .clock     (clock),
    .rst       (rst),
    .fifo_mode (rx_fifo),
    .latency   (latency),
    .wr_valid  (line_bit_valid && rx_buffered),
    .wr_bit    (line_bit),
    .rd_strobe (rx_rd_stb),
    .rd_bit    (rx_rd_bit),
    .slip      (rx_slip)
  );

  always_comb begin
    next_rd_cnt      = rd_cnt;
    next_rx_ser_data = rx_ser_data;
    next_rxclk_out   = 1'b0;
    next_rxclk_oe    = !rx_buffered;
    next_fb_oe       = !rx_buffered || !sdir_in;
    next_fb_out      = 1'b0;
    if (!rx_buffered) begin
      // Bypass: clock and boundary follow the line
      next_rxclk_out = line_clock;
      next_fb_out    = line_frame_start;
      if (line_bit_valid) begin
        next_rx_ser_data = line_bit;
      end
    end else begin
      next_rx_ser_data = rx_rd_bit;
      if (rx_rd_stb) begin
        next_rd_cnt = rd_cnt + 1'b1;
        // An incoming boundary marks the bit just read as bit 0
        if (sdir_in && rx_frame_boundary_in) begin
          next_rd_cnt = CW'(1);
        end
      end
      next_fb_out = !sdir_in && (rd_cnt == '0);
    end
  end

  always_ff @(posedge clock or posedge rst) begin
    if (rst) begin
      rxclk_d               <= 1'b0;
      rd_cnt                <= '0;
      rx_ser_data           <= 1'b0;
      rx_serial_clock_out   <= 1'b0;
      rx_serial_clock_oe    <= 1'b0;
      rx_frame_boundary_out <= 1'b0;
      rx_frame_boundary_oe  <= 1'b0;
    end else begin
      rxclk_d               <= rx_serial_clock_in;
      rd_cnt                <= next_rd_cnt;
      rx_ser_data           <= next_rx_ser_data;
      rx_serial_clock_out   <= next_rxclk_out;
      rx_serial_clock_oe    <= next_rxclk_oe;
      rx_frame_boundary_out <= next_fb_out;
      rx_frame_boundary_oe  <= next_fb_oe;
    end
  end

  // Signaling freeze
  sbf_sig_freeze u_freeze (
    .clock                  (clock),
    .rst                    (rst),
    .force_signaling_freeze (ctrl[CTRL_FORCE]),
    .slip_freeze_enable     (ctrl[CTRL_SFEN]),
    .slip                   (rx_slip),
    .mf_start               (line_mf_start),
    .freeze                 (freeze)
  );

  // Updates arriving while frozen are dropped; the next multiframe refreshes them
  for (genvar i = 0; i < SIG_ENTRIES; i++) begin : g_sig
    always_ff @(posedge clock or posedge rst) begin
      if (rst) begin
        sig_array[i] <= 4'h0;
      end else if (sig_update.valid && sig_update.slot == 5'(i) && !freeze) begin
        sig_array[i] <= sig_update.bits;
      end
    end
  end

  assign next_sig_out = freeze ? rx_signaling_out : sig_array[sig_slot_sel];

  always_ff @(posedge clock or posedge rst) begin
    if (rst) begin
      rx_signaling_out <= 4'h0;
    end else begin
      rx_signaling_out <= next_sig_out;
    end
  end

  // Transmit buffer: serial port writes, line strobe reads
  assign tx_wr_stb = tx_serial_clock_in && !txclk_d && high_speed_mode;
  assign tx_rd_stb = tx_line_strobe && high_speed_mode;

  // Slips here mean the far end broke the sync-to-clock relation
  sbf_slip_buffer #(
    .FRAME_BITS (FRAME_BITS)
  ) u_tx_buf (
    .clock     (clock),
    .rst       (rst),
    .fifo_mode (tx_fifo),
    .latency   (latency),
    .wr_valid  (tx_wr_stb),
    .wr_bit    (tx_ser_data),
    .rd_strobe (tx_rd_stb),
    .rd_bit    (tx_rd_bit),
    .slip      (tx_slip)
  );

  always_comb begin
    next_tx_bit    = tx_line_bit;
    next_tx_mf     = 1'b0;
    next_txclk_oe  = !high_speed_mode;
    next_txclk_out = high_speed_mode ? 1'b0 : line_clock;
    if (high_speed_mode) begin
      next_tx_bit = tx_rd_bit;
    end else if (tx_line_strobe) begin
      next_tx_bit = tx_ser_data;
    end
    if (tx_line_strobe) begin
      next_tx_mf = tx_multiframe_sync;
    end
  end

  always_ff @(posedge clock or posedge rst) begin
    if (rst) begin
      txclk_d             <= 1'b0;
      tx_line_bit         <= 1'b0;
      tx_line_mf_start    <= 1'b0;
      tx_serial_clock_out <= 1'b0;
      tx_serial_clock_oe  <= 1'b0;
    end else begin
      txclk_d             <= tx_serial_clock_in;
      tx_line_bit         <= next_tx_bit;
      tx_line_mf_start    <= next_tx_mf;
      tx_serial_clock_out <= next_txclk_out;
      tx_serial_clock_oe  <= next_txclk_oe;
    end
  end

  default clocking @(posedge clock); endclocking
  default disable iff (rst);

  rxclk_dir_a: assert property (rx_buffered |=> !rx_serial_clock_oe)
    else $error("receive serial clock driven while buffered");
  bypass_sync_a: assert property (!rx_buffered |=> rx_frame_boundary_oe && rx_serial_clock_oe)
    else $error("bypass must drive frame boundary and clock");
  sdir_input_a: assert property (rx_buffered && sdir_in |=> !rx_frame_boundary_oe)
    else $error("frame boundary driven while set as input");
  txclk_in_a: assert property (high_speed_mode |=> !tx_serial_clock_oe)
    else $error("transmit serial clock driven in high-speed mode");
  sig_hold_a: assert property (freeze |=> $stable(rx_signaling_out))
    else $error("signaling output changed while frozen");
  array_hold_a: assert property (freeze |=> $stable(sig_array[sig_slot_sel]))
    else $error("signaling array changed while frozen");
  tx_mode_a: assert property (wr_en && widx == IDX_CTRL |=> tx_fifo == $past(apb_req.pwdata[CTRL_TXFIFO]))
    else $error("transmit buffer mode bit not taken");
  irq_level_a: assert property (rx_slip && irq_mask[IRQ_RX_SLIP] && !wr_en |=> irq)
    else $error("unmasked slip did not raise interrupt");
endmodule : sbf_slip_ctl

// ===== tb/sbf_term_equip.sv
// Purpose: Terminal equipment on the serial ports: serial clocks, frame boundary and transmit data.
// Assumes: Serial clocks run at one eighth of the system clock and only while en is high.
// Notes:   Idle data lines toggle so a stale value never passes for real data.
`timescale 1ns/1ps
module sbf_term_equip #(
  parameter int FRAME_BITS = 32
) (
  // Clock and control
  input  wire logic clock,
  input  wire logic rst,
  input  wire logic en,
  // Serial port pins
  output logic      rx_serial_clock_in,
  output logic      rx_frame_boundary_in,
  output logic      tx_serial_clock_in,
  output logic      tx_ser_data,
  output logic      tx_multiframe_sync
);
  logic [2:0]  ph;
  logic [15:0] nbit;
  always @(posedge clock or posedge rst) begin
    if (rst) begin
      ph <= 3'h0;
      nbit <= 16'h0000;
      {rx_serial_clock_in, rx_frame_boundary_in, tx_serial_clock_in, tx_multiframe_sync} <= 4'h0;
      tx_ser_data <= 1'b0;
    end else if (en) begin
      ph <= ph + 3'h1;
      rx_serial_clock_in <= ph[2];
      tx_serial_clock_in <= ph[2];
      if (ph == 3'h7) begin
        nbit <= nbit + 16'h0001;
        tx_ser_data <= 1'($urandom);
        rx_frame_boundary_in <= (nbit % FRAME_BITS) == 0;
        // Sync derived from the same bit counter as the supplied clock
        tx_multiframe_sync <= (nbit % (16 * FRAME_BITS)) == 0;
      end
    end else begin
      tx_ser_data <= ~tx_ser_data;
      rx_frame_boundary_in <= ~rx_frame_boundary_in;
    end
  end
endmodule : sbf_term_equip

// ===== tb/tb_top.sv
// Purpose: Self-checking bench for the slip buffer and signaling freeze control.
// Assumes: FRAME_BITS shortened to 32; APB answers are checked from a queue of expectations.
// Notes:   Line side traffic and the serial clocks can be stopped so no slip arrives during the interrupt checks.
`timescale 1ns/1ps
module tb_top;
  import sbf_pkg::*;
  logic clock = 0, rst = 1, en = 0, line_on = 0, high_speed_mode = 0;
  logic line_clock = 0, line_bit_valid = 0, line_bit = 0, line_frame_start = 0, line_mf_start = 0;
  logic tx_line_strobe = 0, rxc, rxf, txc, txd, txm, pready, pslverr, irq, rxc_oe, rxf_oe, txc_oe;
  logic [31:0] prdata;
  logic [3:0] sig_out, b1, b2;
  logic [33:0] e;
  logic [11:0] lcnt = 0;
  logic [33:0] exq[$];
  logic sd, rxd = 0, fifo_on = 0;
  logic fq[$];
  logic [1:0] sp = 0;
  logic [31:0] hist = 0;
  int lat = 0;
  sbf_apb_req_t req = '0;
  sbf_sig_update_t sup = '0;
  int n_errors = 0, comparisons = 0;
  always #2 clock = ~clock;
  sbf_term_equip #(.FRAME_BITS(32)) i_term (.clock(clock), .rst(rst), .en(en), .rx_serial_clock_in(rxc),
    .rx_frame_boundary_in(rxf), .tx_serial_clock_in(txc), .tx_ser_data(txd), .tx_multiframe_sync(txm));
  sbf_slip_ctl #(.FRAME_BITS(32)) i_dut (.clock(clock), .rst(rst), .apb_req(req), .prdata(prdata),
    .pready(pready), .pslverr(pslverr), .line_clock(line_clock), .line_bit_valid(line_bit_valid),
    .line_bit(line_bit), .line_frame_start(line_frame_start), .line_mf_start(line_mf_start),
    .rx_serial_clock_in(rxc), .rx_serial_clock_out(), .rx_serial_clock_oe(rxc_oe),
    .rx_frame_boundary_in(rxf), .rx_frame_boundary_out(), .rx_frame_boundary_oe(rxf_oe),
    .rx_ser_data(sd), .sig_update(sup), .sig_slot_sel(5'h03), .rx_signaling_out(sig_out),
    .high_speed_mode(high_speed_mode), .tx_serial_clock_in(txc), .tx_serial_clock_out(),
    .tx_serial_clock_oe(txc_oe), .tx_ser_data(txd), .tx_multiframe_sync(txm),
    .tx_line_strobe(tx_line_strobe), .tx_line_bit(), .tx_line_mf_start(), .irq(irq));
  always @(posedge clock) begin
    lcnt <= lcnt + 12'h001;
    line_clock <= lcnt[2];
    // One bit in eight is skipped so the reader overtakes the writer and slips
    line_bit_valid <= line_on && (lcnt[2:0] == 3'h0) && (lcnt[5:3] != 3'h0);
    line_bit <= 1'($urandom);
    line_frame_start <= (lcnt[7:0] == 8'h00);
    line_mf_start <= (lcnt == 12'h000);
    tx_line_strobe <= (lcnt[2:0] == 3'h4);
  end
  task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
    comparisons++;
    if (seen !== exp) begin
      n_errors++;
      $display("Error at %0t: saw %h expected %h", $time, seen, exp);
    end
  endtask : chk
  always @(posedge clock) if (pready === 1'b1) begin
    e = exq.pop_front();
    chk({31'h0, pslverr}, {31'h0, e[32]});
    if (e[33]) chk(prdata, e[31:0]);
  end
  // Expected FIFO output: the bit written lat writes before the newest
  always @(posedge clock) begin
    rxd <= rxc;
    if (line_bit_valid) hist <= {hist[30:0], line_bit};
    if (fifo_on && rxc && !rxd) fq.push_back(hist[lat]);
  end
  always @(posedge clock) begin
    sp <= {sp[0], fifo_on && rxc && !rxd};
    if (sp[1]) chk({31'h0, sd}, {31'h0, fq.pop_front()});
  end
  task automatic wt(input int n);
    repeat (n) @(posedge clock);
  endtask : wt
  // Bus cycles start right after a rising edge and hold until pready is sampled high
  task automatic apb(input logic w, input logic [15:0] a, input logic [31:0] d, input logic [33:0] x);
    int n;
    n = 0;
    @(posedge clock);
    exq.push_back(x);
    req <= '{psel: 1'b1, penable: 1'b0, pwrite: w, paddr: a, pwdata: d};
    @(posedge clock);
    req.penable <= 1'b1;
    do begin @(posedge clock); n++; end while (pready !== 1'b1 && n < 50);
    if (pready !== 1'b1) n_errors++;
    req.psel <= 1'b0;
    req.penable <= 1'b0;
  endtask : apb
  task automatic wr(input logic [15:0] a, input logic [31:0] d);
    apb(1'b1, a, d, 34'h0_0000_0000);
  endtask : wr
  task automatic rd(input logic [15:0] a, input logic [31:0] x, input logic err);
    apb(1'b0, a, 32'h0000_0000, {1'b1, err, x});
  endtask : rd
  task automatic sig(input logic [3:0] b);
    sup <= '{valid: 1'b1, slot: 5'h03, bits: b};
    @(posedge clock);
    sup.valid <= 1'b0;
  endtask : sig
  task automatic results;
    if (exq.size() != 0 || fq.size() != 0) n_errors++;
    if (n_errors == 0 && comparisons > 0) $display("Simulation passed");
    else $display("Simulation failed");
    $finish;
  endtask : results
  initial begin
    #200000;
    n_errors++;
    results();
  end
  initial begin
    int m, dir;
    logic [31:0] d;
    void'($urandom(33061));
    wt(16);
    rst <= 1'b0;
    wt(1);
    rd(16'h0458, 32'h0000_0005, 1'b0);
    rd(16'h045C, 32'h0000_0000, 1'b0);
    rd(16'h0004, 32'h0000_0000, 1'b1);
    rd(16'h0459, 32'h0000_0000, 1'b1);
    wr(16'h0458, 32'h0000_000D);
    wr(16'h0484, 32'h0000_0001);
    line_on <= 1'b1;
    en <= 1'b1;
    wt(400);
    line_on <= 1'b0;
    en <= 1'b0;
    wt(20);
    // Slip with freeze enabled: the update below must be held back
    sig(4'hA);
    wt(3);
    rd(16'h140C, 32'h0000_0000, 1'b0);
    chk({28'h0, sig_out}, 32'h0000_0000);
    rd(16'h0480, 32'h0000_0001, 1'b0);
    wr(16'h0484, 32'h0000_0001);
    wt(2); chk({31'h0, irq}, 32'h1);
    wr(16'h0484, 32'h0000_0000);
    wt(2); chk({31'h0, irq}, 32'h0);
    wr(16'h0484, 32'h0000_0001);
    wt(2); chk({31'h0, irq}, 32'h1);
    wr(16'h0480, 32'h0000_0003);
    wt(2); chk({31'h0, irq}, 32'h0);
    rd(16'h0480, 32'h0000_0000, 1'b0);
    for (m = 0; m < 4; m++) for (dir = 0; dir < 2; dir++) begin
      d = {24'h0, 1'($urandom), 4'h0, 1'(dir), 2'(m)};
      wr(16'h0458, d);
      rd(16'h0458, d, 1'b0);
      wt(2);
      chk({31'h0, rxc_oe}, {31'h0, (m == 0 || m == 3)});
      chk({31'h0, rxf_oe}, {31'h0, (m == 0 || m == 3 || dir == 0)});
    end
    for (m = 0; m < 2; m++) begin
      high_speed_mode <= 1'(m);
      wt(3);
      chk({31'h0, txc_oe}, {31'h0, !m[0]});
    end
    wr(16'h0458, 32'h0000_0005);
    b1 = 4'($urandom);
    b2 = ~b1;
    sig(b1);
    wt(3);
    rd(16'h140C, {28'h0, b1}, 1'b0);
    wr(16'h0458, 32'h0000_0015);
    wt(2);
    sig(b2);
    wt(3);
    rd(16'h140C, {28'h0, b1}, 1'b0);
    chk({28'h0, sig_out}, {28'h0, b1});
    wr(16'h0458, 32'h0000_0005);
    wt(2);
    sig(b2);
    wt(3);
    rd(16'h140C, {28'h0, b2}, 1'b0);
    chk({28'h0, sig_out}, {28'h0, b2});
    lat = $urandom % 32;
    wr(16'h045C, lat);
    rd(16'h045C, lat, 1'b0);
    wr(16'h0458, 32'h0000_0006);
    line_on <= 1'b1;
    en <= 1'b1;
    fifo_on <= 1'b1;
    wt(300);
    {line_on, en, fifo_on} <= 3'h0;
    wt(4);
    results();
  end
endmodule : tb_top
